// >>> rtl/dbg_trig_pkg.sv
// Package with register map, field positions and reset values of the trigger and status logic.
package dbg_trig_pkg;
  localparam logic [3:0] ADDR_CONTROL  = 4'h0;
  localparam logic [3:0] ADDR_SETUP    = 4'h4;
  localparam logic [3:0] ADDR_STATUS   = 4'h8;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'hc;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h0;

  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_ARM_BIT    = 6;
  localparam int SET_TAG_BIT    = 7;
  localparam int SET_BEGIN_BIT  = 6;
  localparam int STS_AF_BIT     = 7;
  localparam int STS_BF_BIT     = 6;
  localparam int STS_RUN_ACTIVE_FLAG_BIT   = 5;

  localparam logic [7:0] SETUP_RESET   = 8'h00;
  localparam logic [7:0] SETUP_WMASK   = 8'hcf;
  localparam logic [3:0] FIFO_DEPTH    = 4'h8;
  localparam logic [1:0] RESP_OKAY     = 2'b00;
  localparam logic [1:0] RESP_SLVERR   = 2'b10;

  localparam logic [3:0] MODE_A_ONLY    = 4'h0;
  localparam logic [3:0] MODE_A_OR_B    = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B  = 4'h2;
  localparam logic [3:0] MODE_EV_B      = 4'h3;
  localparam logic [3:0] MODE_A_THEN_EV = 4'h4;
  localparam logic [3:0] MODE_A_AND_B   = 4'h5;
  localparam logic [3:0] MODE_A_NOT_B   = 4'h6;
  localparam logic [3:0] MODE_INSIDE    = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE   = 4'h8;

  // Interrupt status bits: run ended, trigger seen.
  localparam int IRQ_END_BIT  = 0;
  localparam int IRQ_TRIG_BIT = 1;
endpackage

// >>> rtl/dbg_trig_status.sv
// Trigger selection, run control and trace status of the debug trace unit.
//
// Operation
// - Setup register always readable; writable only while disarmed; bits 4,5 read zero.
// - Tag qualify set: a match triggers only when the matched opcode executes.
// - Begin/end select: 0 fills circularly until trigger, 1 trigger starts storage.
// - Event-only modes ignore begin/end select and act as begin traces.
// - Modes 0000 A only, 0001 A or B, 0010 A then B, 0011 event B.
// - Modes 0100 A then event B, 0101 A and B, 0110 A and not B.
// - Mode 0111 inside range A..B, mode 1000 outside range.
// - Mode codes 1001 through 1111 never trigger.
// - Trace status register is read-only; writes change nothing.
// - Match A flag clears at run start, sets on match A while armed.
// - Match B flag clears at run start, sets on match B while armed.
// - Run-active flag mirrors arm while enabled; cleared when a run ends.
// - Run ends on FIFO full in begin trace or trigger in end trace.
// - Writing zero to arm or enable ends the run at once.
// - Valid count clears at run start and holds FIFO words 0..8 at end.
// - Valid count never decrements on FIFO reads; host tracks its reads.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module dbg_trig_status
  import dbg_trig_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic [4:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [4:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  input  wire logic        MATCH_A_I,
  input  wire logic        MATCH_B_I,
  input  wire logic        EXEC_A_I,
  input  wire logic        EXEC_B_I,
  input  wire logic        ADDR_GE_A_I,
  input  wire logic        ADDR_LE_B_I,
  input  wire logic        ACCESS_I,
  input  wire logic        FIFO_STORE_I,
  input  wire logic        FIFO_FULL_I,
  output logic             TRIGGER_O,
  output logic             STORE_EN_O,
  output logic             ARMED_O,
  output logic             IRQ_O
);

  logic [7:0] trigger_setup;
  logic       debug_unit_enable;
  logic       arm;
  logic       match_a_flag;
  logic       match_b_flag;
  logic [3:0] fifo_valid_words;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic       a_seen;
  logic       storing;

  // Write channel capture: address and data accepted in either order.
  logic       aw_held;
  logic       w_held;
  logic [4:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       wr_fire;

  assign wr_fire = aw_held && w_held && !BVALID_O;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr   <= 5'h00;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      AWREADY_O <= 1'b0;
      WREADY_O  <= 1'b0;
      BVALID_O  <= 1'b0;
      BRESP_O   <= RESP_OKAY;
    end else begin
      AWREADY_O <= !aw_held && !(AWVALID_I && AWREADY_O);
      WREADY_O  <= !w_held && !(WVALID_I && WREADY_O);
      if (AWVALID_I && AWREADY_O) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_held <= 1'b1;
        w_data <= WDATA_I;
        w_strb <= WSTRB_I;
      end
      if (wr_fire) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O  <= (aw_addr[4] && aw_addr[3:0] != ADDR_IRQ_MASK) ? RESP_SLVERR : RESP_OKAY;
      end else if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
      end
    end
  end

  logic wr_ctl;
  logic wr_setup;
  logic wr_istat;
  logic wr_imask;
  assign wr_ctl   = wr_fire && w_strb[0] && !aw_addr[4] && aw_addr[3:0] == ADDR_CONTROL;
  assign wr_setup = wr_fire && w_strb[0] && !aw_addr[4] && aw_addr[3:0] == ADDR_SETUP;
  assign wr_istat = wr_fire && w_strb[0] && !aw_addr[4] && aw_addr[3:0] == ADDR_IRQ_STAT;
  assign wr_imask = wr_fire && w_strb[0] && aw_addr[4] && aw_addr[3:0] == ADDR_IRQ_MASK;

  // Trigger qualification and mode decode.
  logic qual_a;
  logic qual_b;
  logic event_only;
  logic begin_trace;
  logic next_trig;
  logic [3:0] mode;

  assign mode   = trigger_setup[3:0];
  assign qual_a = trigger_setup[SET_TAG_BIT] ? EXEC_A_I : MATCH_A_I;
  assign qual_b = trigger_setup[SET_TAG_BIT] ? EXEC_B_I : MATCH_B_I;
  assign event_only  = (mode == MODE_EV_B) || (mode == MODE_A_THEN_EV);
  assign begin_trace = event_only || trigger_setup[SET_BEGIN_BIT];

  always_comb begin
    case (mode)
      MODE_A_ONLY:    next_trig = qual_a;
      MODE_A_OR_B:    next_trig = qual_a || qual_b;
      MODE_A_THEN_B:  next_trig = a_seen && qual_b;
      MODE_EV_B:      next_trig = qual_b;
      MODE_A_THEN_EV: next_trig = a_seen && qual_b;
      MODE_A_AND_B:   next_trig = qual_a && qual_b;
      MODE_A_NOT_B:   next_trig = qual_a && !qual_b;
      MODE_INSIDE:    next_trig = ACCESS_I && ADDR_GE_A_I && ADDR_LE_B_I;
      MODE_OUTSIDE:   next_trig = ACCESS_I && !(ADDR_GE_A_I && ADDR_LE_B_I);
      default:        next_trig = 1'b0;
    endcase
  end

  logic run_start;
  logic run_end;
  logic trig_hit;
  assign run_start = wr_ctl && w_data[CTL_ENABLE_BIT] && w_data[CTL_ARM_BIT] && !arm;
  assign trig_hit  = arm && next_trig;
  assign run_end   = arm && ((begin_trace && FIFO_FULL_I) || (!begin_trace && trig_hit));

  // Control: enable and arm.
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      debug_unit_enable <= 1'b0;
      arm               <= 1'b0;
    end else begin
      if (wr_ctl) begin
        debug_unit_enable <= w_data[CTL_ENABLE_BIT];
      end
      // A run end that meets a control write of ones in one cycle must still disarm.
      if (wr_ctl && (!w_data[CTL_ENABLE_BIT] || !w_data[CTL_ARM_BIT])) begin
        arm <= 1'b0;
      end else if (run_start) begin
        arm <= 1'b1;
      end else if (run_end) begin
        arm <= 1'b0;
      end
    end
  end

  // Setup register, writable only while disarmed.
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      trigger_setup <= SETUP_RESET;
    end else if (wr_setup && !arm) begin
      trigger_setup <= w_data[7:0] & SETUP_WMASK;
    end
  end

  // Sequence, flags and storage state of a run.
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      a_seen           <= 1'b0;
      match_a_flag     <= 1'b0;
      match_b_flag     <= 1'b0;
      fifo_valid_words <= 4'h0;
      storing          <= 1'b0;
    end else if (run_start) begin
      a_seen           <= 1'b0;
      match_a_flag     <= 1'b0;
      match_b_flag     <= 1'b0;
      fifo_valid_words <= 4'h0;
      storing          <= !begin_trace;
    end else if (arm) begin
      if (qual_a) begin
        a_seen       <= 1'b1;
        match_a_flag <= 1'b1;
      end
      if (qual_b) begin
        match_b_flag <= 1'b1;
      end
      if (begin_trace && next_trig) begin
        storing <= 1'b1;
      end
      if (run_end) begin
        storing <= 1'b0;
      end
      // Count saturates at the depth; FIFO reads never lower it.
      if (FIFO_STORE_I && storing && fifo_valid_words != FIFO_DEPTH) begin
        fifo_valid_words <= fifo_valid_words + 4'h1;
      end
    end
  end

  // Interrupts: run ended and trigger seen; set wins over clear.
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      irq_status <= 2'b00;
      irq_mask   <= 2'b00;
      IRQ_O      <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~(wr_istat ? w_data[1:0] : 2'b00))
                    | {trig_hit, run_end};
      if (wr_imask) begin
        irq_mask <= w_data[1:0];
      end
      IRQ_O <= |(irq_status & irq_mask);
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      TRIGGER_O  <= 1'b0;
      STORE_EN_O <= 1'b0;
      ARMED_O    <= 1'b0;
    end else begin
      TRIGGER_O  <= trig_hit;
      STORE_EN_O <= storing && arm && !run_end;
      ARMED_O    <= arm && !run_end;
    end
  end

  // Read channel. Status register has no write path at all.
  logic [7:0] status_value;
  logic [31:0] next_rdata;
  logic        next_rerr;
  assign status_value = {match_a_flag, match_b_flag, arm && debug_unit_enable,
                         1'b0, fifo_valid_words};

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr  = 1'b0;
    if (ARADDR_I[4]) begin
      if (ARADDR_I[3:0] == ADDR_IRQ_MASK) begin
        next_rdata = {30'h0, irq_mask};
      end else begin
        next_rerr = 1'b1;
      end
    end else begin
      case (ARADDR_I[3:0])
        ADDR_CONTROL:  next_rdata = {24'h0, debug_unit_enable, arm, 6'h00};
        ADDR_SETUP:    next_rdata = {24'h0, trigger_setup};
        ADDR_STATUS:   next_rdata = {24'h0, status_value};
        ADDR_IRQ_STAT: next_rdata = {30'h0, irq_status};
        default:       next_rerr  = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b0;
      RDATA_O   <= 32'h0000_0000;
      RRESP_O   <= RESP_OKAY;
    end else begin
      ARREADY_O <= !RVALID_O && !(ARVALID_I && ARREADY_O);
      if (ARVALID_I && ARREADY_O) begin
        RVALID_O <= 1'b1;
        RDATA_O  <= next_rdata;
        RRESP_O  <= next_rerr ? RESP_SLVERR : RESP_OKAY;
      end else if (RVALID_O && RREADY_I) begin
        RVALID_O <= 1'b0;
      end
    end
  end

  // Checks.
  property p_setup_locked;
    @(posedge CLK_I) disable iff (!RSTN_I)
      arm |=> (trigger_setup == $past(trigger_setup)) || $past(!arm);
  endproperty
  a_setup_locked: assert property (p_setup_locked) else $error("setup changed while armed");

  property p_reserved_zero;
    @(posedge CLK_I) disable iff (!RSTN_I) trigger_setup[5:4] == 2'b00 && !status_value[4];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_no_trig_high;
    @(posedge CLK_I) disable iff (!RSTN_I) (arm && mode > MODE_OUTSIDE) |=> !TRIGGER_O;
  endproperty
  a_no_trig_high: assert property (p_no_trig_high) else $error("trigger in unused mode");

  property p_a_only;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (arm && mode == MODE_A_ONLY && qual_a) |=> TRIGGER_O;
  endproperty
  a_a_only: assert property (p_a_only) else $error("A match missed");

  property p_start_clears;
    @(posedge CLK_I) disable iff (!RSTN_I)
      run_start |=> !match_a_flag && !match_b_flag && fifo_valid_words == 4'h0;
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("run start did not clear");

  property p_end_disarms;
    @(posedge CLK_I) disable iff (!RSTN_I) run_end |=> !arm ##0 !ARMED_O;
  endproperty
  a_end_disarms: assert property (p_end_disarms) else $error("run end kept arm");

  property p_manual_stop;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (wr_ctl && !(w_data[CTL_ENABLE_BIT] && w_data[CTL_ARM_BIT])) |=> !arm;
  endproperty
  a_manual_stop: assert property (p_manual_stop) else $error("manual stop ignored");

  property p_count_no_drop;
    @(posedge CLK_I) disable iff (!RSTN_I)
      !run_start |=> fifo_valid_words >= $past(fifo_valid_words)
                     && fifo_valid_words <= FIFO_DEPTH;
  endproperty
  a_count_no_drop: assert property (p_count_no_drop)
    else $error("count fell or overflowed");

  property p_begin_event;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (arm && event_only && FIFO_FULL_I) |=> !arm;
  endproperty
  a_begin_event: assert property (p_begin_event) else $error("event mode not begin trace");

  property p_tag_blocks;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (arm && trigger_setup[SET_TAG_BIT] && mode == MODE_A_ONLY && !EXEC_A_I) |=> !TRIGGER_O;
  endproperty
  a_tag_blocks: assert property (p_tag_blocks) else $error("untaken opcode triggered");

  property p_outside;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (arm && mode == MODE_OUTSIDE && ACCESS_I && !(ADDR_GE_A_I && ADDR_LE_B_I)) |=> TRIGGER_O;
  endproperty
  a_outside: assert property (p_outside) else $error("outside access missed");

  property p_event_store;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (arm && event_only && next_trig) |=> storing || !arm;
  endproperty
  a_event_store: assert property (p_event_store) else $error("storage not started");

  property p_idle_count;
    @(posedge CLK_I) disable iff (!RSTN_I)
      (!arm && !run_start) |=> fifo_valid_words == $past(fifo_valid_words);
  endproperty
  a_idle_count: assert property (p_idle_count) else $error("count moved while idle");

  c_run_end:  cover property (@(posedge CLK_I) disable iff (!RSTN_I) run_end);
  c_seq_ab:   cover property (@(posedge CLK_I) disable iff (!RSTN_I)
                 arm && mode == MODE_A_THEN_B && next_trig);
  c_full_cnt: cover property (@(posedge CLK_I) disable iff (!RSTN_I)
                 fifo_valid_words == FIFO_DEPTH);
  c_irq:      cover property (@(posedge CLK_I) disable iff (!RSTN_I) IRQ_O);

endmodule

// >>> dv/fifo_model.sv
// Behavioural model of the trace FIFO datapath beside the trigger logic.
`timescale 1ns/1ns
module fifo_model (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic armed_i,
  input  wire logic store_en_i,
  input  wire logic push_i,
  output logic      store_o,
  output logic      full_o
);
  logic [3:0] words;

  assign full_o = (words == 4'h8);

  // A word is taken only while storage is granted. The fill level is dropped while
  // disarmed, so the first cycles of a new run never see the full flag of the last one.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      words   <= 4'h0;
      store_o <= 1'b0;
    end else begin
      store_o <= push_i && store_en_i && !full_o;
      if (!armed_i) begin
        words <= 4'h0;
      end else if (push_i && store_en_i && !full_o) begin
        words <= words + 4'h1;
      end
    end
  end
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the trigger selection and trace status logic.
`timescale 1ns/1ns
module tb_top;
  import dbg_trig_pkg::*;
  localparam logic [4:0] A_CTL = 5'h00, A_SET = 5'h04, A_STS = 5'h08;
  localparam logic [4:0] A_IRQ = 5'h0c, A_MSK = 5'h10;
  logic        clk, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
  logic        arv = 1'b0, rready = 1'b0, push = 1'b0;
  logic [4:0]  awa = 5'h00, ara = 5'h00;
  logic [31:0] wd = 32'h0;
  logic [5:0]  pat = 6'h00;
  logic        st, full, trig, sten, armed, irq, awr, wr, bv, arr, rv;
  logic [1:0]  br, rr, resp;
  logic [31:0] rd, rword;
  logic [5:0]  s1 [9] = '{6'h00, 6'h00, 6'h10, 6'h00, 6'h10, 6'h00, 6'h00, 6'h05, 6'h07};
  logic [5:0]  s2 [9] = '{6'h10, 6'h08, 6'h08, 6'h08, 6'h08, 6'h18, 6'h18, 6'h07, 6'h05};
  logic [15:0] trig_map = 16'h01bf;
  logic [15:0] run_active_flag_map = 16'hfe58;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          trigs = 0;

  dbg_trig_status u_dbg_trig_status (
    .CLK_I(clk), .RSTN_I(rstn), .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr),
    .WDATA_I(wd), .WSTRB_I(4'hf), .WVALID_I(wv), .WREADY_O(wr), .BRESP_O(br),
    .BVALID_O(bv), .BREADY_I(bready), .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr),
    .RDATA_O(rd), .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rready), .MATCH_A_I(pat[4]),
    .MATCH_B_I(pat[3]), .EXEC_A_I(pat[5]), .EXEC_B_I(pat[5]), .ADDR_GE_A_I(pat[1]),
    .ADDR_LE_B_I(pat[0]), .ACCESS_I(pat[2]), .FIFO_STORE_I(st), .FIFO_FULL_I(full),
    .TRIGGER_O(trig), .STORE_EN_O(sten), .ARMED_O(armed), .IRQ_O(irq));

  fifo_model u_fifo_model (.clk_i(clk), .rstn_i(rstn), .armed_i(armed),
    .store_en_i(sten), .push_i(push), .store_o(st), .full_o(full));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (trig === 1'b1) trigs <= trigs + 1;
  end

  task automatic stop_test();
    $display("Mismatches %0d of %0d comparisons", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    resp = br;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rword = rd;
    resp = rr;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    rd_reg(a);
    chk(rword, {24'h0, e});
  endtask

  task automatic drive(input logic [5:0] p);
    @(posedge clk);
    pat <= p;
    @(posedge clk);
    pat <= 6'h00;
  endtask

  task automatic pushn(input int n);
    @(posedge clk);
    push <= 1'b1;
    repeat (n) @(posedge clk);
    push <= 1'b0;
  endtask

  // Arms one run with setup s (end trace except in the event-only modes), applies two input patterns, then disarms.
  task automatic run_case(input logic [7:0] s, input logic [5:0] p1, input logic [5:0] p2,
                          input logic [1:0] e);
    int t0;
    wr_reg(A_SET, s);
    wr_reg(A_CTL, 8'hc0);
    t0 = trigs;
    drive(p1);
    drive(p2);
    repeat (3) @(posedge clk);
    chk(trigs - t0, e[1]);
    rd_reg(A_STS);
    chk(rword[STS_RUN_ACTIVE_FLAG_BIT], e[0]);
    wr_reg(A_CTL, 8'h80);
  endtask

  initial begin
    #500000;
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(A_SET, 8'h00);
    rchk(A_STS, 8'h00);
    wr_reg(A_SET, 8'hff);
    chk(resp, RESP_OKAY);
    rchk(A_SET, 8'hcf);
    wr_reg(A_STS, 8'hff);
    rchk(A_STS, 8'h00);
    wr_reg(5'h14, 8'h01);
    chk(resp, RESP_SLVERR);
    rd_reg(5'h18);
    chk(resp, RESP_SLVERR);
    for (int m = 0; m < 16; m++) begin
      run_case({4'h0, 4'(m)}, (m < 9) ? s1[m] : 6'h00, (m < 9) ? s2[m] : 6'h1f,
               {trig_map[m], run_active_flag_map[m]});
    end
    run_case(8'h80, 6'h00, 6'h10, 2'b01);
    run_case(8'h80, 6'h00, 6'h30, 2'b10);
    // End trace: three stored words, then a trigger on comparator A closes the run.
    wr_reg(A_IRQ, 8'h03);
    wr_reg(A_SET, 8'h00);
    wr_reg(A_CTL, 8'hc0);
    rchk(A_STS, 8'h20);
    pushn(3);
    wr_reg(A_SET, 8'hc5);
    drive(6'h10);
    repeat (3) @(posedge clk);
    rchk(A_STS, 8'h83);
    rchk(A_SET, 8'h00);
    rchk(A_IRQ, 8'h03);
    chk(irq, 1'b0);
    wr_reg(A_MSK, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr_reg(A_IRQ, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    rchk(A_IRQ, 8'h02);
    // Begin trace: storage waits for the trigger and the run ends on a full FIFO.
    wr_reg(A_SET, 8'h41);
    wr_reg(A_CTL, 8'hc0);
    pushn(2);
    chk(sten, 1'b0);
    drive(6'h08);
    repeat (3) @(posedge clk);
    chk(sten, 1'b1);
    pushn(10);
    repeat (3) @(posedge clk);
    rchk(A_STS, 8'h48);
    rchk(A_STS, 8'h48);
    // Manual stops through the enable bit and through the arm bit.
    wr_reg(A_CTL, 8'hc0);
    rchk(A_STS, 8'h20);
    wr_reg(A_CTL, 8'h40);
    rchk(A_STS, 8'h00);
    chk(armed, 1'b0);
    wr_reg(A_CTL, 8'hc0);
    wr_reg(A_CTL, 8'h80);
    rchk(A_STS, 8'h00);
    stop_test();
  end
endmodule
